// *** nvsram_host_pkg.sv ***
// constants for the host-side controller of a 32k x 8 nonvolatile sram
// assumes a 100 mhz clock and that the memory pins are wired straight to the controller
package nvsram_host_pkg;

  // ----------------------------------------
  // array geometry
  // ----------------------------------------
  localparam int addr_width = 15;
  localparam int data_width = 8;

  // ----------------------------------------
  // timing, in ns, and cycle counts at 100 mhz
  // ----------------------------------------
  localparam int clk_period_ns = 10;
  localparam int access_ns = 50;       // strobe hold time, covers the slowest grade
  localparam int access_cycles = (access_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int save_pulse_ns = 50;   // save pulse target; the host-made pulse runs one cycle longer, 60 ns
  localparam int save_pulse_cycles = (save_pulse_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int busy_settle_cycles = 2; // let the busy line settle after release

  // ----------------------------------------
  // host sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {st_idle, st_setup, st_strobe, st_hold, st_save, st_settle} host_state_t;

endpackage

// *** cycle_timer.sv ***
// down counter that flags when a loaded count has run out
// assumes load and run are never asserted to overrun the count width
`timescale 1ns/1ns
module cycle_timer #(
  parameter int width = 8
) (
  input wire logic clk,              // system clock
  input wire logic reset,            // async reset, active high
  input wire logic load,             // load a new count
  input wire logic [width-1:0] count, // cycles to run
  output logic done                  // high while count is zero
);

  // ----------------------------------------
  // counter
  // ----------------------------------------
  logic [width-1:0] left_q;

  // reload on request, otherwise count down to zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      left_q <= '0;
    else if (load)
      left_q <= count;
    else if (left_q != '0)
      left_q <= left_q - 1'b1;
  end

  // done looks only at the count: the sequencer decides its loads from done, so a load term here would close a loop
  assign done = (left_q == '0);

endmodule

// *** nvsram_host.sv ***
// host-side controller driving the pins of a 32k x 8 nonvolatile sram
// assumes the memory pins connect directly; the testbench resolves the shared wires
`timescale 1ns/1ns
module nvsram_host #(
  parameter int addr_w = nvsram_host_pkg::addr_width,
  parameter int data_w = nvsram_host_pkg::data_width
) (
  input wire logic clk,                      // system clock
  input wire logic reset,                    // async reset, active high
  input wire logic req_valid,                // user access request
  input wire logic req_write,                // 1 write, 0 read
  input wire logic [addr_w-1:0] req_addr,    // user byte address
  input wire logic [data_w-1:0] req_wdata,   // user write data
  input wire logic save_req,                 // user asks for a hardware save
  output logic req_ready,                    // controller idle and memory not busy
  output logic rsp_valid,                    // one-cycle end of access or save
  output logic [data_w-1:0] rsp_rdata,       // read data
  output logic mem_busy,                     // busy line seen low
  output logic [addr_w-1:0] byte_address,    // memory address pins
  output logic [data_w-1:0] data_bus_o,      // data bus drive value
  output logic data_bus_oe,                  // data bus driven by host
  input wire logic [data_w-1:0] data_bus_i,  // data bus level
  output logic chip_sel_n,                   // chip select, active low
  output logic write_n,                      // write strobe, active low
  output logic out_en_n,                     // output enable, active low
  output logic save_busy_line_n_o,           // busy line drive value, always 0
  output logic save_busy_line_n_oe,          // busy line pulled low by host
  input wire logic save_busy_line_n_i        // busy line level
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (addr_w != 15) $error("address width must be 15");
  if (data_w != 8) $error("data width must be 8");

  // ----------------------------------------
  // state and timer
  // ----------------------------------------
  nvsram_host_pkg::host_state_t state_q;
  logic wr_q;
  logic tmr_load;
  logic [7:0] tmr_count;
  logic tmr_done;
  logic busy_seen;

  assign busy_seen = !save_busy_line_n_i;

  cycle_timer #(.width(8)) u_timer (
    .clk(clk),
    .reset(reset),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // timer loads on each state entry that needs a wait
  always_comb
  begin
    tmr_load = 1'b0;
    tmr_count = 8'h00;
    case (state_q)
      nvsram_host_pkg::st_idle:
      begin
        if (save_req && !busy_seen)
        begin
          tmr_load = 1'b1;
          tmr_count = 8'(nvsram_host_pkg::save_pulse_cycles);
        end
        else if (req_valid && !busy_seen)
        begin
          tmr_load = 1'b1;
          tmr_count = 8'h01;
        end
      end
      nvsram_host_pkg::st_setup:
      begin
        // one setup cycle runs out first; the strobe then spans the count plus its final cycle
        if (tmr_done)
        begin
          tmr_load = 1'b1;
          tmr_count = 8'(nvsram_host_pkg::access_cycles - 1);
        end
      end
      nvsram_host_pkg::st_save:
      begin
        if (tmr_done)
        begin
          tmr_load = 1'b1;
          tmr_count = 8'(nvsram_host_pkg::busy_settle_cycles);
        end
      end
      default:
      begin
        tmr_load = 1'b0;
        tmr_count = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // access order: idle, setup, strobe, hold; save: idle, save, settle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state_q <= nvsram_host_pkg::st_idle;
    else
      case (state_q)
        nvsram_host_pkg::st_idle:
        begin
          if (!busy_seen && save_req)
            state_q <= nvsram_host_pkg::st_save;
          else if (!busy_seen && req_valid)
            state_q <= nvsram_host_pkg::st_setup;
        end
        nvsram_host_pkg::st_setup:
          if (tmr_done)
            state_q <= nvsram_host_pkg::st_strobe;
        nvsram_host_pkg::st_strobe:
          if (tmr_done)
            state_q <= nvsram_host_pkg::st_hold;
        nvsram_host_pkg::st_hold:
          state_q <= nvsram_host_pkg::st_idle;
        nvsram_host_pkg::st_save:
          if (tmr_done)
            state_q <= nvsram_host_pkg::st_settle;
        nvsram_host_pkg::st_settle:
          if (tmr_done && !busy_seen)
            state_q <= nvsram_host_pkg::st_idle;
        default:
          state_q <= nvsram_host_pkg::st_idle;
      endcase
  end

  // ----------------------------------------
  // latched request
  // ----------------------------------------
  // address and write data held for the whole access
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_q <= 1'b0;
      byte_address <= '0;
      data_bus_o <= '0;
    end
    else if (state_q == nvsram_host_pkg::st_idle && req_valid && !save_req && !busy_seen)
    begin
      wr_q <= req_write;
      byte_address <= req_addr;
      data_bus_o <= req_wdata;
    end
  end

  // ----------------------------------------
  // pin strobes
  // ----------------------------------------
  // chip select spans setup and strobe, rising as hold begins, so the address is latched on its fall
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      chip_sel_n <= 1'b1;
      write_n <= 1'b1;
      out_en_n <= 1'b1;
      data_bus_oe <= 1'b0;
    end
    else
    begin
      chip_sel_n <= !(tmr_load && state_q == nvsram_host_pkg::st_idle && !save_req
        || state_q == nvsram_host_pkg::st_setup
        || state_q == nvsram_host_pkg::st_strobe && !tmr_done);
      write_n <= !(wr_q && state_q == nvsram_host_pkg::st_setup && tmr_done
        || wr_q && state_q == nvsram_host_pkg::st_strobe && !tmr_done);
      out_en_n <= !(!wr_q && state_q == nvsram_host_pkg::st_setup && tmr_done
        || !wr_q && state_q == nvsram_host_pkg::st_strobe && !tmr_done);
      // host drives the bus only for writes, never with output enable low
      data_bus_oe <= wr_q && (state_q == nvsram_host_pkg::st_setup
        || state_q == nvsram_host_pkg::st_strobe);
    end
  end

  // ----------------------------------------
  // save pulse on the busy line
  // ----------------------------------------
  // host only pulls low; release leaves the line to the device pull-up
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      save_busy_line_n_oe <= 1'b0;
    else
      save_busy_line_n_oe <= (state_q == nvsram_host_pkg::st_idle && save_req && !busy_seen)
        || (state_q == nvsram_host_pkg::st_save && !tmr_done);
  end

  assign save_busy_line_n_o = 1'b0;

  // ----------------------------------------
  // answers
  // ----------------------------------------
  // read data sampled at the end of the strobe while output enable is still low
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= (state_q == nvsram_host_pkg::st_strobe && tmr_done)
        || (state_q == nvsram_host_pkg::st_settle && tmr_done && !busy_seen);
      if (state_q == nvsram_host_pkg::st_strobe && tmr_done && !wr_q)
        rsp_rdata <= data_bus_i;
    end
  end

  // ready and busy status; automatic saves and restores show only as busy
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      req_ready <= 1'b0;
      mem_busy <= 1'b0;
    end
    else
    begin
      mem_busy <= busy_seen;
      req_ready <= (state_q == nvsram_host_pkg::st_idle) && !tmr_load && !busy_seen;
    end
  end

endmodule

// *** nvsram_host_checker.sv ***
// timing checks on the pins of the host-side nvsram controller
// assumes the design's default address and data widths
`timescale 1ns/1ns
module nvsram_host_checker (
  input wire logic clk, // system clock
  input wire logic reset, // async reset
  input wire logic rsp_valid, // end of access
  input wire logic mem_busy, // busy seen
  input wire logic [14:0] byte_address, // address pins
  input wire logic data_bus_oe, // host drives bus
  input wire logic chip_sel_n, // chip select
  input wire logic write_n, // write strobe
  input wire logic out_en_n, // output enable
  input wire logic save_busy_line_n_oe, // host pulls busy
  input wire logic save_busy_line_n_i // busy level
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // step sequences
  // ----------------------------------------
  sequence s_sel_low;
    !chip_sel_n[*7] ##1 chip_sel_n;
  endsequence
  sequence s_low5(logic s);
    !s[*5] ##1 s;
  endsequence
  property p_sel; $fell(chip_sel_n) |-> s_sel_low; endproperty
  a_sel: assert property (p_sel) else $error("select width wrong");
  property p_addr; $fell(chip_sel_n) |=> $stable(byte_address)[*6]; endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_wr; $fell(write_n) |-> $past(!chip_sel_n) ##0 s_low5(write_n); endproperty
  a_wr: assert property (p_wr) else $error("write strobe wrong");
  property p_rd; $fell(out_en_n) |-> !data_bus_oe ##0 s_low5(out_en_n); endproperty
  a_rd: assert property (p_rd) else $error("read strobe wrong");
  property p_wdrv; !write_n |-> data_bus_oe && !chip_sel_n; endproperty
  a_wdrv: assert property (p_wdrv) else $error("write without data");
  property p_float; data_bus_oe |-> out_en_n; endproperty
  a_float: assert property (p_float) else $error("bus fight");
  property p_wait; $fell(chip_sel_n) |-> $past(save_busy_line_n_i) && !save_busy_line_n_oe; endproperty
  a_wait: assert property (p_wait) else $error("access while busy");
  property p_save; $rose(save_busy_line_n_oe) |-> save_busy_line_n_oe[*6] ##1 !save_busy_line_n_oe; endproperty
  a_save: assert property (p_save) else $error("save pulse wrong");
  property p_busy; !save_busy_line_n_i |=> mem_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy not seen");
  property p_done; $rose(chip_sel_n) |-> rsp_valid ##1 !rsp_valid; endproperty
  a_done: assert property (p_done) else $error("response wrong");
endmodule
bind nvsram_host nvsram_host_checker u_chk (.clk(clk), .reset(reset), .rsp_valid(rsp_valid), .mem_busy(mem_busy),
  .byte_address(byte_address), .data_bus_oe(data_bus_oe), .chip_sel_n(chip_sel_n), .write_n(write_n),
  .out_en_n(out_en_n), .save_busy_line_n_oe(save_busy_line_n_oe), .save_busy_line_n_i(save_busy_line_n_i));

// *** nvsram_dev_model.sv ***
// behavioural model of the 32k x 8 nonvolatile sram
// assumes the bench resolves the data bus and the busy line
`timescale 1ns/1ns
module nvsram_dev_model #(
  parameter int save_cycles = 20
) (
  input wire logic clk, // times saves
  input wire logic [14:0] byte_address, // address pins
  input wire logic [7:0] data_in, // bus level
  input wire logic chip_sel_n, // chip select
  input wire logic write_n, // write strobe
  input wire logic out_en_n, // output enable
  input wire logic busy_i, // busy level
  input wire logic power_fail, // power loss pulse
  input wire logic power_up, // power-up pulse
  output logic [7:0] dq_o, // read data
  output logic dq_oe, // drives bus
  output logic busy_oe // pulls busy low
);
  logic [7:0] sram_q [0:32767];
  logic [7:0] nv_q [0:32767];
  logic [14:0] lat_addr;
  int busy_cnt = 0;
  // latch address just after select falls, once the host's new address stands
  always @(negedge chip_sel_n) #1 lat_addr = byte_address;
  // drive only while selected and enabled
  assign dq_oe = !chip_sel_n && !out_en_n && write_n && busy_cnt == 0;
  assign dq_o = sram_q[lat_addr];
  assign busy_oe = busy_cnt != 0;
  // save and restore copies
  always @(posedge clk)
  begin
    if (power_up)
    begin
      sram_q = nv_q;
      busy_cnt <= save_cycles;
    end
    else if (busy_cnt == 0 && (!busy_i || power_fail))
    begin
      nv_q = sram_q;
      busy_cnt <= save_cycles;
    end
    else if (busy_cnt > 0)
      busy_cnt <= busy_cnt - 1;
    // a write lands while select and strobe are both low; select and strobe rise together
    if (!chip_sel_n && !write_n && busy_cnt == 0)
      sram_q[lat_addr] = data_in;
  end
endmodule

// *** nvsram_host_bench.sv ***
// self-checking bench for the host-side nvsram controller
// assumes the device model and the bound checker
`timescale 1ns/1ns
module nvsram_host_bench;
  logic clk, reset, req_valid, req_write, save_req, req_ready, rsp_valid, mem_busy, data_bus_oe;
  logic chip_sel_n, write_n, out_en_n, busy_o, busy_oe, dq_oe, dev_busy_oe, busy_i, power_fail, power_up;
  logic [14:0] req_addr, byte_address, a;
  logic [7:0] req_wdata, rsp_rdata, data_bus_o, data_bus_i, dq_o, last_q, d;
  logic [7:0] ref_q [int];
  logic [7:0] ref_nv [int];
  logic [14:0] addrs [$];
  int error_cnt = 0, total_checks = 0, cyc = 0, seed;
  nvsram_host u_dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .save_req(save_req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_busy(mem_busy), .byte_address(byte_address), .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe),
    .data_bus_i(data_bus_i), .chip_sel_n(chip_sel_n), .write_n(write_n), .out_en_n(out_en_n),
    .save_busy_line_n_o(busy_o), .save_busy_line_n_oe(busy_oe), .save_busy_line_n_i(busy_i));
  nvsram_dev_model u_dev (.clk(clk), .byte_address(byte_address), .data_in(data_bus_i), .chip_sel_n(chip_sel_n),
    .write_n(write_n), .out_en_n(out_en_n), .busy_i(busy_i), .power_fail(power_fail), .power_up(power_up),
    .dq_o(dq_o), .dq_oe(dq_oe), .busy_oe(dev_busy_oe));
  // wire levels: pull-up on busy, undriven bus flips
  assign busy_i = (busy_oe ? busy_o : 1'b1) && !dev_busy_oe;
  assign data_bus_i = data_bus_oe ? data_bus_o : dq_oe ? dq_o : ~last_q;
  always @(posedge clk) last_q <= data_bus_i;
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // kind 0 read, 1 write, 2 save; held until the pins show it taken, then wait for the response
  task automatic op(input int kind, input logic [14:0] ad, input logic [7:0] dt);
    req_valid = kind < 2;
    save_req = kind == 2;
    req_write = kind == 1;
    req_addr = ad;
    req_wdata = dt;
    do @(posedge clk); while (chip_sel_n !== 1'b0 && busy_oe !== 1'b1);
    #1;
    req_valid = 0;
    save_req = 0;
    if (kind == 1)
      ref_q[ad] = dt;
    if (kind == 2)
      ref_nv = ref_q;
    while (rsp_valid !== 1'b1) @(posedge clk);
    #1;
    if (kind == 0) check(rsp_rdata, ref_q[ad]);
    @(posedge clk);
    #1;
    check(req_ready, 1'b1);
  endtask
  task automatic pulse_check(input logic fail);
    power_fail = fail;
    power_up = !fail;
    if (fail)
      ref_nv = ref_q;
    else
      ref_q = ref_nv;
    @(posedge clk);
    #1;
    power_fail = 0;
    power_up = 0;
    repeat (3) @(posedge clk);
    #1;
    check(mem_busy, 1'b1);
    check(req_ready, 1'b0);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    {reset, req_valid, req_write, save_req, power_fail, power_up} = 6'h20;
    req_addr = 15'h0000;
    req_wdata = 8'h00;
    last_q = 8'h00;
    seed = $urandom(27427);
    repeat (8) @(posedge clk);
    #1 reset = 0;
    // boundary and random writes back to back, then read back
    for (int i = 0; i < 12; i++)
    begin
      a = i == 0 ? 15'h0000 : i == 1 ? 15'h7fff : 15'($urandom);
      d = 8'($urandom);
      addrs.push_back(a);
      op(1, a, d);
    end
    foreach (addrs[j]) op(0, addrs[j], 8'h00);
    // host save, overwrite, restore brings saved byte back
    op(2, 15'h0000, 8'h00);
    op(1, addrs[2], ~ref_q[addrs[2]]);
    pulse_check(1'b0);
    op(0, addrs[2], 8'h00);
    // power loss saves new byte without host action
    op(1, addrs[3], 8'h5a);
    pulse_check(1'b1);
    pulse_check(1'b0);
    op(0, addrs[3], 8'h00);
    complete_run();
  end
endmodule
